// ==== cido_params.svh ====
// constants of the inc/dec/or/branch execution block
// assumes a 14-bit instruction word and a 40 MHz instruction clock
`ifndef CIDO_PARAMS_SVH
`define CIDO_PARAMS_SVH

// ==========================================
// instruction word fields
`define CIDO_OP6_MSB      13
`define CIDO_OP6_LSB      8
`define CIDO_DEST_BIT     7
`define CIDO_FADDR_MSB    6
`define CIDO_OP3_LSB      11
`define CIDO_BR_MSB       10
`define CIDO_LIT_MSB      7
`define CIDO_LATCH_HI     4
`define CIDO_LATCH_LO     3

// ==========================================
// opcode codes
`define CIDO_OP_DEC_SKIP  6'h0b
`define CIDO_OP_INC_SKIP  6'h0f
`define CIDO_OP_INC       6'h0a
`define CIDO_OP_OR_REG    6'h04
`define CIDO_OP_OR_LIT    6'h38
`define CIDO_OP3_BRANCH   3'h5

// ==========================================
// reset values
`define CIDO_RST_PC       13'h0000
`define CIDO_RST_ACC      8'h00
`define CIDO_RST_ZERO     1'b0
`define CIDO_RST_BYTE     8'h00

`endif

// ==== cido_pkg.sv ====
// types of the inc/dec/or/branch execution block
// assumes nothing beyond the constants header
package cido_pkg;
   // ==========================================
   // sequencer states, one-hot
   typedef enum logic [1:0] {
      CIDO_ST_EXEC = 2'b01,  // executes the word on the bus
      CIDO_ST_IDLE = 2'b10   // second cycle, word discarded
   } cido_state_t;
endpackage

// ==== cido_core.sv ====
// execution of the decrement/increment-skip, increment, or and branch subset
// assumes program memory presents one word per clock with a valid strobe,
// and the upper address latch comes from logic on the same clock
//
// Notes on behaviour
// RL1: decrement_skip_on_null subtracts one from register 0..127, flags untouched.
// RL2: a zero decrement result turns the next word into an idle cycle.
// RL3: destination bit 0 writes accumulator, 1 writes the addressed register.
// RL4: increment_skip_on_null adds one, flags untouched, zero result skips next word.
// RL5: branch loads 11-bit immediate into pc 10:0, latch bits 4:3 into pc 12:11.
// RL6: branch takes immediates 0..2047, always two cycles, flags unchanged.
// RL7: or literal ORs accumulator with 8-bit literal, stores accumulator, zero flag only.
// RL8: increment_register_op adds one, routes by destination, updates zero, never skips.
// RL9: or register ORs accumulator with register, routes by destination, zero flag only.
// RL10: zero flag set when the 8-bit result is zero; single-cycle ops take one cycle.
`include "cido_params.svh"

module cido_core #(
   parameter int REG_COUNT = 128
) (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // program memory word
   input  wire logic        i_instr_valid,
   input  wire logic [13:0] i_instr,
   // upper address latch contents
   input  wire logic [4:0]  i_upper_address_latch,
   // register observation
   input  wire logic [6:0]  i_peek_addr,
   output logic      [7:0]  o_peek_data,
   // architectural state
   output logic      [12:0] o_pc,
   output logic      [7:0]  o_accumulator,
   output logic             o_zero_flag,
   output logic             o_idle_cycle,
   output logic             o_retire
);

   // ==========================================
   // state
   cido_pkg::cido_state_t state;
   cido_pkg::cido_state_t next_state;
   logic [12:0]           next_pc;
   logic [7:0]            next_acc;
   logic                  next_zero;
   logic                  next_retire;
   logic [7:0]            next_peek;
   logic                  hold_pc;
   logic                  next_hold;
   logic                  wr_en;
   logic [6:0]            wr_addr;
   logic [7:0]            wr_data;
   logic [7:0]            regs [REG_COUNT];

   // ==========================================
   // decode
   logic                  fire;
   logic [5:0]            op6;
   logic [6:0]            faddr;
   logic                  dest_reg;
   logic [7:0]            operand;
   logic [7:0]            lit;
   logic [10:0]           br_target;
   logic                  is_dec_skip;
   logic                  is_inc_skip;
   logic                  is_inc;
   logic                  is_or_reg;
   logic                  is_or_lit;
   logic                  is_branch;
   logic [7:0]            dec_val;
   logic [7:0]            inc_val;

   // words seen in the idle cycle are dropped, not executed
   assign fire        = (state == cido_pkg::CIDO_ST_EXEC) && i_instr_valid;
   assign op6         = i_instr[`CIDO_OP6_MSB:`CIDO_OP6_LSB];
   assign faddr       = i_instr[`CIDO_FADDR_MSB:0];
   assign dest_reg    = i_instr[`CIDO_DEST_BIT];
   assign operand     = regs[faddr];
   assign lit         = i_instr[`CIDO_LIT_MSB:0];
   assign br_target   = i_instr[`CIDO_BR_MSB:0];
   assign is_dec_skip = fire && (op6 == `CIDO_OP_DEC_SKIP);
   assign is_inc_skip = fire && (op6 == `CIDO_OP_INC_SKIP);
   assign is_inc      = fire && (op6 == `CIDO_OP_INC);
   assign is_or_reg   = fire && (op6 == `CIDO_OP_OR_REG);
   assign is_or_lit   = fire && (op6 == `CIDO_OP_OR_LIT);
   assign is_branch   = fire && (i_instr[`CIDO_OP6_MSB:`CIDO_OP3_LSB] == `CIDO_OP3_BRANCH);
   assign dec_val     = operand - 8'h01;
   assign inc_val     = operand + 8'h01;

   // ==========================================
   // next-state logic
   always_comb begin
      logic [7:0] res;
      logic       to_dest;
      res         = 8'h00;
      to_dest     = 1'b0;
      next_state  = cido_pkg::CIDO_ST_EXEC;
      next_pc     = o_pc;
      next_acc    = o_accumulator;
      next_zero   = o_zero_flag;
      next_retire = 1'b0;
      next_hold   = 1'b0;
      wr_en       = 1'b0;
      wr_addr     = faddr;
      wr_data     = 8'h00;
      next_peek   = regs[i_peek_addr];
      case (state)
         cido_pkg::CIDO_ST_IDLE: begin
            // a skipped word still occupies an address, so pc moves past it;
            // after a branch pc already names the target, which must run next
            next_retire = 1'b1;
            next_pc     = hold_pc ? o_pc : o_pc + 13'h0001;       // see RL5
         end
         cido_pkg::CIDO_ST_EXEC: begin
            if (fire) begin
               next_retire = 1'b1;
               next_pc     = o_pc + 13'h0001;
               if (is_dec_skip) begin
                  res     = dec_val;                               // see RL1
                  to_dest = 1'b1;
                  if (dec_val == 8'h00) begin
                     next_state = cido_pkg::CIDO_ST_IDLE;          // see RL2
                  end
               end else if (is_inc_skip) begin
                  res     = inc_val;                               // see RL4
                  to_dest = 1'b1;
                  if (inc_val == 8'h00) begin
                     next_state = cido_pkg::CIDO_ST_IDLE;          // see RL4
                  end
               end else if (is_inc) begin
                  res       = inc_val;                             // see RL8
                  to_dest   = 1'b1;
                  next_zero = (inc_val == 8'h00);                  // see RL10
               end else if (is_or_reg) begin
                  res       = o_accumulator | operand;             // see RL9
                  to_dest   = 1'b1;
                  next_zero = (res == 8'h00);                      // see RL10
               end else if (is_or_lit) begin
                  res       = o_accumulator | lit;                 // see RL7
                  next_acc  = res;
                  next_zero = (res == 8'h00);                      // see RL10
               end else if (is_branch) begin
                  // flags untouched, second cycle forced
                  next_pc    = {i_upper_address_latch[`CIDO_LATCH_HI:`CIDO_LATCH_LO], br_target}; // see RL5
                  next_state = cido_pkg::CIDO_ST_IDLE;             // see RL6
                  next_hold  = 1'b1;                               // see RL5
               end
               // destination select for register-operand forms
               if (to_dest) begin
                  if (dest_reg) begin
                     wr_en   = 1'b1;                               // see RL3
                     wr_data = res;
                  end else begin
                     next_acc = res;                               // see RL3
                  end
               end
            end
         end
         default: begin
            next_state = cido_pkg::CIDO_ST_EXEC;
         end
      endcase
   end

   // ==========================================
   // registers; the file itself has no reset, like any data memory
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state         <= cido_pkg::CIDO_ST_EXEC;
         o_pc          <= `CIDO_RST_PC;
         o_accumulator <= `CIDO_RST_ACC;
         o_zero_flag   <= `CIDO_RST_ZERO;
         o_retire      <= 1'b0;
         o_peek_data   <= `CIDO_RST_BYTE;
         hold_pc       <= 1'b0;
      end else begin
         state         <= next_state;
         o_pc          <= next_pc;
         o_accumulator <= next_acc;
         o_zero_flag   <= next_zero;
         o_retire      <= next_retire;
         o_peek_data   <= next_peek;
         hold_pc       <= next_hold;
      end
   end

   // plain clocked process: the file may be preloaded from outside, which always_ff forbids
   always @(posedge i_clk) begin
      if (wr_en && !i_sys_rst) begin
         regs[wr_addr] <= wr_data;
      end
   end

   // one-hot bit of the idle state, taken straight from the state flop
   assign o_idle_cycle = state[1];

   // ==========================================
   // checks
   sequence two_cycle_s;
      o_idle_cycle ##1 !o_idle_cycle;
   endsequence

   sequence one_cycle_s;
      !o_idle_cycle;
   endsequence

   property p_dec_skip;
      @(posedge i_clk) disable iff (i_sys_rst)
         (is_dec_skip && operand == 8'h01) |=> two_cycle_s;
   endproperty

   dec_skip_a: assert property (p_dec_skip) // see RL2
      else $error("decrement to zero did not skip");

   dec_noskip_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RL1
      (is_dec_skip && operand != 8'h01 && !dest_reg) |=> one_cycle_s
         and (o_accumulator == $past(dec_val)) and $stable(o_zero_flag))
      else $error("decrement result or flag wrong");

   inc_skip_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RL4
      (is_inc_skip && operand == 8'hff) |=> two_cycle_s and $stable(o_zero_flag))
      else $error("increment to zero did not skip");

   branch_pc_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RL5
      is_branch |=> o_pc == {$past(i_upper_address_latch[4:3]), $past(br_target)})
      else $error("branch target wrong");

   branch_two_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RL6
      is_branch |=> (two_cycle_s and $stable(o_zero_flag)) ##0 (o_retire && (o_pc == $past(o_pc))))
      else $error("branch not two cycles");

   or_lit_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RL7
      is_or_lit |=> (o_accumulator == ($past(o_accumulator) | $past(lit)))
         && (o_zero_flag == (o_accumulator == 8'h00)))
      else $error("or literal result wrong");

   inc_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RL8
      (is_inc && !dest_reg) |=> !o_idle_cycle && (o_accumulator == $past(inc_val))
         && (o_zero_flag == ($past(inc_val) == 8'h00)))
      else $error("increment result or zero flag wrong");

   or_reg_dest_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RL9
      (is_or_reg && dest_reg) |=> $stable(o_accumulator)
         && (regs[$past(faddr)] == ($past(o_accumulator) | $past(operand))))
      else $error("or register write-back wrong");

   single_pc_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see RL10
      (fire && !is_branch && !is_dec_skip && !is_inc_skip) |=> o_pc == $past(o_pc) + 13'h0001 && !o_idle_cycle)
      else $error("single-cycle op took extra cycle");

endmodule // cido_core

// ==== cido_prog_mem.sv ====
// program memory model that hands the core one instruction word per fetch
// assumes the core's pc addresses it and the bench loads mem before a run
module cido_prog_mem (
   // fetch side
   input  wire logic        i_en,
   input  wire logic [12:0] i_addr,
   output logic             o_valid,
   output logic      [13:0] o_word
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // storage
   logic [13:0] mem [0:8191];
   // unused words decode as no known opcode, so a stray fetch only moves pc
   initial begin
      for (int a = 0; a < 8192; a++) begin
         mem[a] = 14'h0000;
      end
   end
   // combinational fetch, word follows pc within the same cycle
   assign o_valid = i_en;
   assign o_word  = mem[i_addr];
endmodule // cido_prog_mem

// ==== core_inc_dec_or_branch_ops_test.sv ====
// self-checking bench for the inc/dec/or/branch execution block
// assumes the register file is reachable as DUT.regs for presetting
`include "cido_params.svh"
module core_inc_dec_or_branch_ops_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // signals
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        en = 1'b0;
   logic        valid;
   logic [13:0] word;
   logic [4:0]  latch = 5'h00;
   logic [6:0]  peek_addr = 7'h00;
   logic [7:0]  peek_data;
   logic [12:0] pc;
   logic [7:0]  acc;
   logic        zero;
   logic        idle;
   logic        retire;
   int          idle_cnt = 0;
   int          retire_cnt = 0;
   int          err_total = 0;
   int          tests_run = 0;
   int          cyc = 0;
   always #12.5 clk = ~clk;
   cido_prog_mem PM (.i_en(en), .i_addr(pc), .o_valid(valid), .o_word(word));
   cido_core DUT (.i_clk(clk), .i_sys_rst(sys_rst), .i_instr_valid(valid), .i_instr(word),
      .i_upper_address_latch(latch), .i_peek_addr(peek_addr), .o_peek_data(peek_data),
      .o_pc(pc), .o_accumulator(acc), .o_zero_flag(zero), .o_idle_cycle(idle), .o_retire(retire));
   // ==========================================
   // shared tasks
   task automatic summarize;
      if (err_total == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // short reset, then exactly n fetch edges, each retiring one cycle
   task automatic run(input int n);
      sys_rst = 1'b1;
      @(posedge clk);
      #1 sys_rst = 1'b0;
      idle_cnt = 0;
      retire_cnt = 0;
      en = 1'b1;
      repeat (n) @(posedge clk);
      #1 en = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("retire", n, retire_cnt);
   endtask
   task automatic peek(input logic [6:0] a, input logic [7:0] exp);
      peek_addr = a;
      repeat (2) @(posedge clk);
      #1 chk("reg", {5'h00, exp}, {5'h00, peek_data});
   endtask
   // ==========================================
   // scenarios; skipped word is or-literal 0 in t_dec, which would raise zero, and or-literal 80 in t_inc
   task automatic t_dec;
      PM.mem[0] = {`CIDO_OP_DEC_SKIP, 1'b1, 7'h05};
      PM.mem[1] = {`CIDO_OP_OR_LIT, 8'h00};
      PM.mem[2] = {`CIDO_OP_DEC_SKIP, 1'b0, 7'h06};
      DUT.regs[5] = 8'h01;
      DUT.regs[6] = 8'h03;
      run(5);
      chk("idle", 13'h1, idle_cnt);
      chk("acc", 13'h02, acc);
      chk("zero", 13'h0, zero);
      chk("pc", 13'h0005, pc);
      peek(7'h05, 8'h00);
      peek(7'h06, 8'h03);
   endtask
   task automatic t_inc;
      PM.mem[0] = {`CIDO_OP_INC_SKIP, 1'b1, 7'h07};
      PM.mem[1] = {`CIDO_OP_OR_LIT, 8'h80};
      PM.mem[2] = {`CIDO_OP_INC, 1'b0, 7'h08};
      PM.mem[3] = {`CIDO_OP_INC, 1'b1, 7'h09};
      DUT.regs[7] = 8'hff;
      DUT.regs[8] = 8'h41;
      DUT.regs[9] = 8'hff;
      run(5);
      chk("idle", 13'h1, idle_cnt);
      chk("acc", 13'h42, acc);
      chk("zero", 13'h1, zero);
      peek(7'h07, 8'h00);
      peek(7'h08, 8'h41);
      peek(7'h09, 8'h00);
   endtask
   task automatic t_or;
      PM.mem[0] = {`CIDO_OP_OR_LIT, 8'h00};
      PM.mem[1] = {`CIDO_OP_OR_LIT, 8'h5a};
      PM.mem[2] = {`CIDO_OP_OR_REG, 1'b1, 7'h0a};
      PM.mem[3] = {`CIDO_OP_OR_REG, 1'b0, 7'h0b};
      DUT.regs[10] = 8'h81;
      DUT.regs[11] = 8'h24;
      run(5);
      chk("idle", 13'h0, idle_cnt);
      chk("acc", 13'h7e, acc);
      chk("zero", 13'h0, zero);
      peek(7'h0a, 8'hdb);
      peek(7'h0b, 8'h24);
   endtask
   // latch bits 2:0 set to show they are ignored
   task automatic t_branch;
      latch = 5'b10111;
      PM.mem[0] = {`CIDO_OP_OR_LIT, 8'h00};
      PM.mem[1] = {`CIDO_OP3_BRANCH, 11'h010};
      // target word must run; it leaves zero alone, so zero still shows the or-literal
      PM.mem[13'h1010] = {`CIDO_OP_INC_SKIP, 1'b0, 7'h0c};
      DUT.regs[12] = 8'h10;
      run(4);
      chk("idle", 13'h1, idle_cnt);
      chk("pc", 13'h1011, pc);
      chk("acc", 13'h11, acc);
      chk("zero", 13'h1, zero);
   endtask
   // ==========================================
   // pulse counters, read mid-cycle where the outputs are settled
   always @(negedge clk) begin
      if (!sys_rst) begin
         if (idle === 1'b1) begin
            idle_cnt++;
         end
         if (retire === 1'b1) begin
            retire_cnt++;
         end
      end
   end
   // ==========================================
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      #1 sys_rst = 1'b0;
      t_dec();
      t_inc();
      t_or();
      t_branch();
      summarize();
   end
endmodule // core_inc_dec_or_branch_ops_test
